// ===== smr_bus_master.sv
// Serial bus master model for the register bank
`timescale 1ns/100ps
module smr_bus_master (
  input  wire logic sys_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // Idle bus: clock parked high, data left to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #10;
  endtask : wait_cyc
  // 800 ns bit time, well above 50 kHz, so the complete flag is usable
  task automatic put_bit(input logic b, output logic s);
    sda_low_out = ~b;
    wait_cyc(2);
    scl_out = 1'b1;
    wait_cyc(4);
    s = sda_in;
    scl_out = 1'b0;
    wait_cyc(2);
  endtask : put_bit
  task automatic put_byte(input logic [7:0] v, output logic ack, output logic [7:0] rd);
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], rd[i]);
    end
    put_bit(1'b1, ack);
  endtask : put_byte
  task automatic start_cond();
    wait_cyc(4);
    sda_low_out = 1'b1;
    wait_cyc(4);
    scl_out = 1'b0;
    wait_cyc(2);
  endtask : start_cond
  task automatic stop_cond();
    sda_low_out = 1'b1;
    wait_cyc(2);
    scl_out = 1'b1;
    wait_cyc(4);
    sda_low_out = 1'b0;
    wait_cyc(4);
  endtask : stop_cond
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] val,
                           output logic [2:0] acks);
    logic [7:0] rd;
    start_cond();
    put_byte({dev, 1'b0}, acks[2], rd);
    put_byte(ra, acks[1], rd);
    put_byte(val, acks[0], rd);
    stop_cond();
  endtask : write_reg
  // Pointer write, then one byte read closed by a not-acknowledge
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] val);
    logic a;
    start_cond();
    put_byte({dev, 1'b0}, a, val);
    put_byte(ra, a, val);
    stop_cond();
    start_cond();
    put_byte({dev, 1'b1}, a, val);
    put_byte(8'hFF, a, val);
    stop_cond();
  endtask : read_reg
endmodule : smr_bus_master

// ===== smr_conv_seq.sv
// Conversion sequencer: timed conversion, result capture and complete flag
`timescale 1ns/100ps
module smr_conv_seq
  import smr_pkg::*;
#(
  parameter int CYCLES = smr_pkg::CONV_CYCLES
) (
  input  wire logic                         sys_clk_in,
  input  wire logic                         reset_n_in,
  input  wire logic                         start_in,
  input  wire logic [smr_pkg::RESULT_W-1:0] conv_data_in,
  output logic                              conv_start_out,
  output logic                              done_out,
  output logic      [smr_pkg::RESULT_W-1:0] result_out
);

  import smr_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic          busy_q;
  logic [CW-1:0] count_q;

  // Restart on every request, even mid-conversion
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      busy_q  <= 1'b0;
      count_q <= '0;
    end else if (start_in) begin
      busy_q  <= 1'b1; // [R11] [R16]
      count_q <= '0;
    end else if (busy_q) begin
      if (count_q == LAST) begin
        busy_q <= 1'b0;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= start_in;
    end
  end

  // Flag drops on request, rises only when the latest one ends
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b1;
    end else if (start_in) begin
      done_out <= 1'b0; // [R12] [R16]
    end else if (busy_q && count_q == LAST) begin
      done_out <= 1'b1; // [R12]
    end
  end

  // Held until the next completion so both byte reads match
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      result_out <= '0;
    end else if (!start_in && busy_q && count_q == LAST) begin
      result_out <= conv_data_in; // [R22]
    end
  end

endmodule : smr_conv_seq

// ===== smr_pkg.sv
// Shared constants and types for the supply monitor serial register bank
package smr_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_MON_STATUS_MID   = 8'h01;
  localparam logic [7:0] ADDR_MON_STATUS_UPPER = 8'h02;
  localparam logic [7:0] ADDR_DRIVE_STATUS_LOW = 8'h03;
  localparam logic [7:0] ADDR_LOGIC_SENSE      = 8'h06;
  localparam logic [7:0] ADDR_RESULT_LOW       = 8'h07;
  localparam logic [7:0] ADDR_RESULT_HIGH      = 8'h08;
  localparam logic [7:0] ADDR_CONV_CONTROL     = 8'h09;
  localparam logic [7:0] ADDR_GP_DRIVE         = 8'h0E;
  localparam logic [7:0] ADDR_PLD_OVERRIDE     = 8'h11;

  // Reset values
  localparam logic [4:0] CONV_CONTROL_RESET = 5'h1F;
  localparam logic [7:0] GP_DRIVE_RESET     = 8'h04;
  localparam logic [2:0] PLD_OVERRIDE_RESET = 3'h0;

  // Field positions
  localparam int RANGE_BIT        = 4;
  localparam int CHANNEL_MSB      = 3;
  localparam int DONE_BIT         = 0;
  localparam int ALERT_RELEASE_BIT = 2;

  // Fill value for non-functional bits and unmapped addresses
  localparam logic [7:0] FILL_ONES = 8'hFF;

  // Widths
  localparam int RESULT_W    = 12;
  localparam int DRIVE_W     = 8;
  localparam int SENSE_W     = 4;
  localparam int MON_W       = 12;

  // Timing
  localparam int CLK_FREQ_KHZ   = 10000;
  localparam int CONV_TIME_US   = 200;
  localparam int CONV_CYCLES    = (CONV_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

  // Serial transfer states
  typedef enum logic [3:0] {
    SMR_IDLE,
    SMR_DEV_ADDR,
    SMR_DEV_ACK,
    SMR_REG_ADDR,
    SMR_REG_ACK,
    SMR_WR_DATA,
    SMR_WR_ACK,
    SMR_RD_DATA,
    SMR_RD_ACK,
    SMR_IGNORE
  } smr_bus_state_type;

endpackage : smr_pkg

// ===== smr_register_bank.sv
// Serial-bus register bank of the supply monitor
`timescale 1ns/100ps
// Summary of operation
// [R1] Write: address byte with write bit, register byte, one data byte, each acked.
// [R2] Mid monitor status holds 5A,5B..8A,8B from bit 0 upward.
// [R3] Upper monitor status holds 9A,9B,10A,10B in bits 0-3, ones above.
// [R4] Every non-functional bit reads back as one.
// [R5] Converter measures any monitor channel through three registers.
// [R6] Low result: result bits 3-0 in 7-4, ones in 3-1, done flag bit 0.
// [R7] High result holds result bits 11 down to 4.
// [R8] Control: range bit 4, channel field bits 3-0, bits 7-5 unused.
// [R9] Range 0 gives 2.048 V span, range 1 gives 6.144 V span.
// [R10] Codes 0-9 pick channels one to ten, 12 analog, 13 sense supply.
// [R11] Any control write starts a conversion with written settings.
// [R12] Done flag reads 0 while converting, 1 once result is readable.
// [R13] Master reads low and high result in two separate reads.
// [R14] Master should start again only after done or after conversion time.
// [R15] Below 50 kHz serial clock the master must wait full conversion time.
// [R16] A request during conversion delays done until the later one ends.
// [R17] Sense status holds the four input levels in bits 0-3, ones above.
// [R18] Override bits 3-1 drive PLD inputs 4-2 only where selected.
// [R19] Drive status shows internal drive value, two gate drives then outputs 3-8.
// [R20] Each output takes PLD or register value per its configuration bit.
// [R21] Drive register maps bits 1-8 to 0-7, bit 2 is alert release.
// [R22] Result registers hold the last completed value until the next.
module smr_register_bank
  import smr_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h40,
  parameter int         CONV_CYCLES_P = smr_pkg::CONV_CYCLES
) (
  input  wire logic                         sys_clk_in,
  input  wire logic                         reset_n_in,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe_out,
  input  wire logic [smr_pkg::MON_W-1:0]    mon_cmp_in,
  input  wire logic [smr_pkg::SENSE_W-1:0]  logic_sense_in,
  input  wire logic [2:0]                   input_source_sel_in,
  output logic      [smr_pkg::SENSE_W-1:0]  pld_input_out,
  input  wire logic [smr_pkg::DRIVE_W-1:0]  pld_drive_in,
  input  wire logic [smr_pkg::DRIVE_W-1:0]  drive_source_sel_in,
  output logic      [smr_pkg::DRIVE_W-1:0]  drive_out,
  input  wire logic [smr_pkg::RESULT_W-1:0] conv_data_in,
  output logic                              conv_start_out,
  output logic      [3:0]                   conv_channel_out,
  output logic                              conv_range_out
);

  import smr_pkg::*;

  // Synchronised pins
  logic [1:0]          bus_s;
  logic [MON_W-1:0]    mon_s;
  logic [SENSE_W-1:0]  sense_s;
  logic                scl_prev_q;
  logic                sda_prev_q;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;

  // Serial engine
  smr_bus_state_type   state_q;
  logic [3:0]          bit_cnt_q;
  logic [7:0]          rx_q;
  logic [7:0]          tx_q;
  logic [7:0]          reg_ptr_q;
  logic                wr_stb_q;
  logic [7:0]          rd_view;

  // Registers
  logic [4:0]          conv_control_q;
  logic [7:0]          gp_drive_q;
  logic [2:0]          pld_override_q;
  logic                conv_req_q;
  logic                conv_done;
  logic [RESULT_W-1:0] conv_result;

  smr_sync2 #(.W(2)) u_bus_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({scl_in, sda_in}),
    .sync_out   (bus_s)
  );

  smr_sync2 #(.W(MON_W + SENSE_W)) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({mon_cmp_in, logic_sense_in}),
    .sync_out   ({mon_s, sense_s})
  );

  smr_conv_seq #(.CYCLES(CONV_CYCLES_P)) u_conv (
    .sys_clk_in     (sys_clk_in),
    .reset_n_in     (reset_n_in),
    .start_in       (conv_req_q),
    .conv_data_in   (conv_data_in),
    .conv_start_out (conv_start_out),
    .done_out       (conv_done),
    .result_out     (conv_result)
  );

  // Edge history; idle bus is high
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= bus_s[1];
      sda_prev_q <= bus_s[0];
    end
  end

  assign scl_rise  = bus_s[1] && !scl_prev_q;
  assign scl_fall  = !bus_s[1] && scl_prev_q;
  assign start_det = bus_s[1] && scl_prev_q && sda_prev_q && !bus_s[0];
  assign stop_det  = bus_s[1] && scl_prev_q && !sda_prev_q && bus_s[0];

  // Readback view; unmapped addresses read all ones
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    logic [7:0] v;
    v = FILL_ONES; // [R4]
    if (addr == ADDR_MON_STATUS_MID) begin
      v = mon_s[7:0]; // [R2]
    end else if (addr == ADDR_MON_STATUS_UPPER) begin
      v = {4'hF, mon_s[11:8]}; // [R3] [R4]
    end else if (addr == ADDR_DRIVE_STATUS_LOW) begin
      v = drive_out; // [R19]
    end else if (addr == ADDR_LOGIC_SENSE) begin
      v = {4'hF, sense_s}; // [R17]
    end else if (addr == ADDR_RESULT_LOW) begin
      v = {conv_result[3:0], 3'h7, conv_done}; // [R6] [R12]
    end else if (addr == ADDR_RESULT_HIGH) begin
      v = conv_result[11:4]; // [R7]
    end else if (addr == ADDR_CONV_CONTROL) begin
      v = {3'h7, conv_control_q}; // [R8] [R4]
    end else if (addr == ADDR_GP_DRIVE) begin
      v = gp_drive_q; // [R21]
    end else if (addr == ADDR_PLD_OVERRIDE) begin
      v = {4'hF, pld_override_q, 1'b1}; // [R4]
    end
    return v;
  endfunction : read_reg

  // Byte a read would present now; a select on a call result is not portable
  always_comb begin
    rd_view = read_reg(reg_ptr_q);
  end

  // Serial transfer engine; acks are driven on the falling clock edge
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_q    <= SMR_IDLE;
      bit_cnt_q  <= 4'h0;
      rx_q       <= 8'h00;
      tx_q       <= 8'h00;
      reg_ptr_q  <= 8'h00;
      wr_stb_q   <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (stop_det) begin
        state_q    <= SMR_IDLE;
        sda_oe_out <= 1'b0;
      end else if (start_det) begin
        state_q    <= SMR_DEV_ADDR; // [R1]
        bit_cnt_q  <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          SMR_DEV_ADDR, SMR_REG_ADDR, SMR_WR_DATA: begin
            rx_q      <= {rx_q[6:0], bus_s[0]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          SMR_RD_DATA: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          SMR_DEV_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              if (rx_q[7:1] == DEVICE_ADDR) begin
                state_q    <= SMR_DEV_ACK;
                sda_oe_out <= 1'b1; // [R1]
              end else begin
                state_q <= SMR_IGNORE;
              end
            end
          end
          SMR_DEV_ACK: begin
            bit_cnt_q <= 4'h0;
            if (rx_q[0]) begin
              // Read byte is frozen here so a busy bus sees one value
              tx_q       <= rd_view;
              sda_oe_out <= !rd_view[7];
              state_q    <= SMR_RD_DATA;
            end else begin
              sda_oe_out <= 1'b0;
              state_q    <= SMR_REG_ADDR;
            end
          end
          SMR_REG_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              state_q    <= SMR_REG_ACK;
              sda_oe_out <= 1'b1; // [R1]
            end
          end
          SMR_REG_ACK: begin
            reg_ptr_q  <= rx_q;
            bit_cnt_q  <= 4'h0;
            sda_oe_out <= 1'b0;
            state_q    <= SMR_WR_DATA;
          end
          SMR_WR_DATA: begin
            if (bit_cnt_q == 4'h8) begin
              state_q    <= SMR_WR_ACK;
              sda_oe_out <= 1'b1; // [R1]
              wr_stb_q   <= 1'b1;
            end
          end
          SMR_WR_ACK: begin
            // Only one data byte per write; later bytes go unacked
            sda_oe_out <= 1'b0;
            state_q    <= SMR_IGNORE;
          end
          SMR_RD_DATA: begin
            if (bit_cnt_q == 4'h8) begin
              sda_oe_out <= 1'b0;
              state_q    <= SMR_RD_ACK;
            end else begin
              tx_q       <= {tx_q[6:0], 1'b1};
              sda_oe_out <= !tx_q[6];
            end
          end
          SMR_RD_ACK: begin
            state_q <= SMR_IGNORE;
          end
          default: begin
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Converter control register; any write requests a conversion
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      conv_control_q <= CONV_CONTROL_RESET;
      conv_req_q     <= 1'b0;
    end else begin
      conv_req_q <= 1'b0;
      if (wr_stb_q && reg_ptr_q == ADDR_CONV_CONTROL) begin
        conv_control_q <= rx_q[RANGE_BIT:0]; // [R8]
        conv_req_q     <= 1'b1; // [R11] [R5]
      end
    end
  end

  // Range and channel straight to the analog front end
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      conv_channel_out <= CONV_CONTROL_RESET[CHANNEL_MSB:0];
      conv_range_out   <= CONV_CONTROL_RESET[RANGE_BIT];
    end else begin
      conv_channel_out <= conv_control_q[CHANNEL_MSB:0]; // [R10]
      conv_range_out   <= conv_control_q[RANGE_BIT]; // [R9]
    end
  end

  // General-purpose drive and PLD override registers
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      gp_drive_q     <= GP_DRIVE_RESET;
      pld_override_q <= PLD_OVERRIDE_RESET;
    end else if (wr_stb_q) begin
      if (reg_ptr_q == ADDR_GP_DRIVE) begin
        gp_drive_q <= rx_q; // [R21]
      end else if (reg_ptr_q == ADDR_PLD_OVERRIDE) begin
        pld_override_q <= rx_q[3:1]; // [R18]
      end
    end
  end

  // Output source select per bit; bit 2 doubles as alert release
  genvar gi;
  generate
    for (gi = 0; gi < DRIVE_W; gi++) begin : g_drive
      always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
          drive_out[gi] <= 1'b0;
        end else begin
          drive_out[gi] <= drive_source_sel_in[gi] ? gp_drive_q[gi] : pld_drive_in[gi]; // [R20]
        end
      end
    end
  endgenerate

  // Input one always comes from its pin
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pld_input_out <= '0;
    end else begin
      pld_input_out[0] <= sense_s[0];
      for (int i = 1; i < SENSE_W; i++) begin
        pld_input_out[i] <= input_source_sel_in[i-1] ? pld_override_q[i-1] : sense_s[i]; // [R18]
      end
    end
  end

endmodule : smr_register_bank

// ===== smr_register_bank_assertions.sv
// Port-level checks for the supply monitor register bank
`timescale 1ns/100ps
module smr_register_bank_assertions
  import smr_pkg::*;
(
  input wire logic                         sys_clk_in,
  input wire logic                         reset_n_in,
  input wire logic                         scl_in,
  input wire logic                         sda_in,
  input wire logic                         sda_out,
  input wire logic                         sda_oe_out,
  input wire logic [smr_pkg::SENSE_W-1:0]  logic_sense_in,
  input wire logic [2:0]                   input_source_sel_in,
  input wire logic [smr_pkg::SENSE_W-1:0]  pld_input_out,
  input wire logic [smr_pkg::DRIVE_W-1:0]  pld_drive_in,
  input wire logic [smr_pkg::DRIVE_W-1:0]  drive_source_sel_in,
  input wire logic [smr_pkg::DRIVE_W-1:0]  drive_out,
  input wire logic                         conv_start_out,
  input wire logic [3:0]                   conv_channel_out,
  input wire logic                         conv_range_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_stop;
    $rose(sda_in) && scl_in && $past(scl_in);
  endsequence
  sequence s_setting_quiet;
    $stable({conv_channel_out, conv_range_out}) [*8];
  endsequence
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin output value not low");
  a_idle_after_stop: assert property (s_stop |=> !sda_oe_out [*8])
    else $error("data line pulled right after a stop");
  // Synchroniser lag may put a release at the clock rise, so skip two cycles
  a_ack_steady_high: assert property ($rose(scl_in) |-> ##2 $stable(sda_oe_out) [*3])
    else $error("data line changed while serial clock high");
  a_start_pulse_gap: assert property (conv_start_out |=> !conv_start_out [*8])
    else $error("start pulse longer than one cycle");
  a_setting_with_start: assert property (
    $changed({conv_channel_out, conv_range_out}) |-> conv_start_out)
    else $error("converter setting changed without a start");
  a_setting_hold: assert property (conv_start_out |=> s_setting_quiet)
    else $error("converter setting moved during conversion");
  a_pld_drive_path: assert property ($past(reset_n_in) |->
    ((drive_out ^ $past(pld_drive_in)) & ~$past(drive_source_sel_in)) == 8'h00)
    else $error("output not following its logic source");
  // Selector must settle too, or a repeated pin value hides a source swap
  a_pld_input_pins: assert property (
    $stable({logic_sense_in, input_source_sel_in}) [*6] |->
    ((pld_input_out ^ logic_sense_in) & ~{input_source_sel_in, 1'b0}) == 4'h0)
    else $error("logic input not following its pin");
endmodule : smr_register_bank_assertions

// ===== smr_register_bank_test.sv
// Self-checking bench for the supply monitor register bank
`timescale 1ns/100ps
module smr_register_bank_test;
  import smr_pkg::*;
  localparam logic [6:0] DEV  = 7'h40;
  localparam int         CONV = 600;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        scl_in;
  logic        sda_in;
  logic        sda_out;
  logic        sda_oe_out;
  logic        m_low;
  logic [11:0] mon_cmp_in = 12'h000;
  logic [3:0]  logic_sense_in = 4'h0;
  logic [2:0]  input_source_sel_in = 3'h0;
  logic [3:0]  pld_input_out;
  logic [7:0]  pld_drive_in = 8'h00;
  logic [7:0]  drive_source_sel_in = 8'h00;
  logic [7:0]  drive_out;
  logic [11:0] conv_data_in = 12'h000;
  logic        conv_start_out;
  logic [3:0]  conv_channel_out;
  logic        conv_range_out;
  logic [7:0]  starts = 8'h00;
  logic [3:0]  codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                              4'hC, 4'hD};
  int          seed = 46;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc_n = 0;
  int          t_start = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  assign sda_in = ~(m_low | sda_oe_out);
  always @(posedge sys_clk_in) begin
    cyc_n <= cyc_n + 1;
    if (conv_start_out === 1'b1) begin
      starts  <= starts + 8'h01;
      t_start <= cyc_n;
    end
  end
  smr_register_bank #(.DEVICE_ADDR(DEV), .CONV_CYCLES_P(CONV)) i_dut (
    .sys_clk_in, .reset_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .mon_cmp_in,
    .logic_sense_in, .input_source_sel_in, .pld_input_out, .pld_drive_in,
    .drive_source_sel_in, .drive_out, .conv_data_in, .conv_start_out, .conv_channel_out,
    .conv_range_out);
  smr_bus_master i_master (.sys_clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(m_low));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #10;
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_master.read_reg(DEV, a, v);
    check(v, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [2:0] acks;
    i_master.write_reg(DEV, a, v, acks);
    check({5'h00, acks}, 8'h00);
  endtask : wr
  // Repeated low result reads until the complete flag shows
  task automatic poll_done(output logic [7:0] v);
    v = 8'h00;
    for (int n = 0; n < 8 && v[0] !== 1'b1; n++) begin
      i_master.read_reg(DEV, ADDR_RESULT_LOW, v);
    end
  endtask : poll_done
  function automatic logic [7:0] exp_drive(input logic [7:0] r);
    return (r & drive_source_sel_in) | (pld_drive_in & ~drive_source_sel_in);
  endfunction : exp_drive
  function automatic logic [3:0] exp_pld(input logic [7:0] w);
    logic [3:0] m;
    m = {input_source_sel_in, 1'b0};
    return (w[3:0] & m) | (logic_sense_in & ~m);
  endfunction : exp_pld
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    #8_000_000;
    error_cnt++;
    summarize();
  end
  initial begin
    logic [7:0]  v;
    logic [7:0]  w;
    logic [7:0]  ctl;
    logic [2:0]  acks;
    logic [11:0] last;
    int          t1;
    last = 12'h000;
    cyc(6);
    reset_n_in = 1'b1;
    cyc(4);
    rd(ADDR_CONV_CONTROL, 8'hFF);
    rd(ADDR_GP_DRIVE, GP_DRIVE_RESET);
    rd(ADDR_PLD_OVERRIDE, 8'hF1);
    rd(ADDR_RESULT_LOW, 8'h0F);
    rd(ADDR_RESULT_HIGH, 8'h00);
    rd(8'h05, FILL_ONES);
    repeat (3) begin
      mon_cmp_in = 12'($random(seed));
      logic_sense_in = 4'($random(seed));
      cyc(6);
      rd(ADDR_MON_STATUS_MID, mon_cmp_in[7:0]);
      rd(ADDR_MON_STATUS_UPPER, {4'hF, mon_cmp_in[11:8]});
      rd(ADDR_LOGIC_SENSE, {4'hF, logic_sense_in});
    end
    wr(ADDR_MON_STATUS_MID, ~mon_cmp_in[7:0]);
    rd(ADDR_MON_STATUS_MID, mon_cmp_in[7:0]);
    i_master.write_reg(DEV ^ 7'h01, ADDR_GP_DRIVE, 8'hAA, acks);
    check({7'h00, acks[2]}, 8'h01);
    rd(ADDR_GP_DRIVE, GP_DRIVE_RESET);
    repeat (3) begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      drive_source_sel_in = 8'($random(seed));
      pld_drive_in = 8'($random(seed));
      input_source_sel_in = 3'($random(seed));
      logic_sense_in = 4'($random(seed));
      wr(ADDR_GP_DRIVE, v);
      wr(ADDR_PLD_OVERRIDE, w);
      check(drive_out, exp_drive(v));
      check({4'h0, pld_input_out}, {4'h0, exp_pld(w)});
      rd(ADDR_DRIVE_STATUS_LOW, exp_drive(v));
      rd(ADDR_GP_DRIVE, v);
      rd(ADDR_PLD_OVERRIDE, {4'hF, w[3:1], 1'b1});
    end
    foreach (codes[i]) begin
      conv_data_in = 12'($random(seed));
      ctl = {3'($random(seed)), 1'($random(seed)), codes[i]};
      wr(ADDR_CONV_CONTROL, ctl);
      check(starts, 8'(i + 1));
      check({3'h0, conv_range_out, conv_channel_out}, {3'h0, ctl[4:0]});
      rd(ADDR_RESULT_LOW, {last[3:0], 4'hE});
      rd(ADDR_CONV_CONTROL, {3'h7, ctl[4:0]});
      poll_done(v);
      check(v, {conv_data_in[3:0], 4'hF});
      rd(ADDR_RESULT_HIGH, conv_data_in[11:4]);
      last = conv_data_in;
    end
    // Second start lands mid-conversion; flag must wait for the later one
    // Gap kept short so the second request beats the first completion
    conv_data_in = 12'($random(seed));
    wr(ADDR_CONV_CONTROL, 8'h10);
    t1 = t_start;
    cyc(200);
    wr(ADDR_CONV_CONTROL, 8'h0C);
    check(starts, 8'h0E);
    while (cyc_n < t1 + CONV + 5) begin
      cyc(1);
    end
    rd(ADDR_RESULT_LOW, {last[3:0], 4'hE});
    poll_done(v);
    check(v, {conv_data_in[3:0], 4'hF});
    summarize();
  end
endmodule : smr_register_bank_test
bind smr_register_bank smr_register_bank_assertions i_chk (
  .sys_clk_in, .reset_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .logic_sense_in,
  .input_source_sel_in, .pld_input_out, .pld_drive_in, .drive_source_sel_in, .drive_out,
  .conv_start_out, .conv_channel_out, .conv_range_out);

// ===== smr_sync2.sv
// Two-flop synchroniser for a vector of unrelated level inputs
`timescale 1ns/100ps
module smr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : smr_sync2
